// File: shared/sensor_param_consts.vh
/*
  Offsets, field positions and reset values of the sensor parameter entries.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SENSOR_PARAM_CONSTS_VH
`define SENSOR_PARAM_CONSTS_VH
// ===========================================================
// Offsets
`define OFS_PENDING_BUS_ADDRESS 8'h00
`define OFS_CHANNEL_ENABLE_LIST 8'h01
`define OFS_EMITTER_SELECT_ONE_TWO 8'h02
`define OFS_EMITTER_SELECT_THREE 8'h03
`define OFS_PROXIMITY_ALIGNMENT 8'h05
`define OFS_AMBIENT_ALIGNMENT 8'h06
`define OFS_AMBIENT_INFRARED_GAIN 8'h1e
`define OFS_AMBIENT_INFRARED_RANGE 8'h1f
// ===========================================================
// Reset values
`define RST_PENDING_BUS_ADDRESS 8'h00
`define RST_CHANNEL_ENABLE_LIST 8'h00
`define RST_EMITTER_SELECT_ONE_TWO 8'h21
`define RST_EMITTER_SELECT_THREE 8'h04
`define RST_PROXIMITY_ALIGNMENT 8'h00
`define RST_AMBIENT_ALIGNMENT 8'h00
`define RST_AMBIENT_INFRARED_GAIN 8'h00
`define RST_AMBIENT_INFRARED_RANGE 8'h00
`define RST_ACTIVE_BUS_ADDRESS 8'h00
// ===========================================================
// Writable bit masks (reserved bits are held at zero)
`define MASK_CHANNEL_ENABLE_LIST 8'hf7
`define MASK_EMITTER_SELECT_ONE_TWO 8'h77
`define MASK_EMITTER_SELECT_THREE 8'h07
`define MASK_PROXIMITY_ALIGNMENT 8'h70
`define MASK_AMBIENT_ALIGNMENT 8'h30
`define MASK_AMBIENT_INFRARED_GAIN 8'h0f
`define MASK_AMBIENT_INFRARED_RANGE 8'h20
// ===========================================================
// Field positions
`define BIT_UV_INDEX_ENABLE 7
`define BIT_AUX_ENABLE 6
`define BIT_AMBIENT_INFRARED_ENABLE 5
`define BIT_AMBIENT_VISIBLE_ENABLE 4
`define BIT_PROXIMITY_THREE_ENABLE 2
`define BIT_PROXIMITY_TWO_ENABLE 1
`define BIT_PROXIMITY_ONE_ENABLE 0
`define BIT_PROXIMITY_ONE_ALIGN 4
`define BIT_PROXIMITY_TWO_ALIGN 5
`define BIT_PROXIMITY_THREE_ALIGN 6
`define BIT_AMBIENT_INFRARED_ALIGN 5
`define BIT_AMBIENT_VISIBLE_ALIGN 4
`define BIT_INFRARED_RANGE_SELECT 5
`endif

// File: design/sensor_parameter_config.v
/*
  Parameter entry bank of a light sensor: pending/active bus address, channel
  enables, emitter masks, 17-to-16-bit result alignment and infrared gain/range.
  Assumes a same-clock register port master and a sequencer that feeds
  conversions tagged with a channel number.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "sensor_param_consts.vh"

// Function
// - Active bus address changes only on apply command, not on entry write.
// - Bit 7 enables UV index; result goes to auxiliary result pair.
// - Bit 6 enables auxiliary channel; result to the same auxiliary pair.
// - Bit 5 enables ambient infrared, bit 4 ambient visible, own results.
// - Bits 2..0 enable proximity three..one, own results; bit 3 reserved.
// - Emitter masks one (2:0) and two (6:4); bit n drives emitter n+1.
// - Emitter mask three in bits 2:0 of second select entry; rest reserved.
// - Proximity align bits 6..4 pick low 16 bits when set, else upper.
// - Ambient align bits 5 and 4 pick low or upper 16 bits likewise.
module sensor_parameter_config
#(
  parameter CHANNEL_COUNT = 7
)
(
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire bus_address_apply_command,
  output reg [7:0] active_bus_address,
  output reg [7:0] channel_enables,
  output reg [2:0] emitter_mask_one,
  output reg [2:0] emitter_mask_two,
  output reg [2:0] emitter_mask_three,
  output reg [3:0] infrared_gain,
  output reg infrared_range_select,
  input wire conv_valid,
  input wire [2:0] conv_channel,
  input wire [16:0] conv_value,
  output reg result_valid,
  output reg [2:0] result_slot,
  output reg [15:0] result_data
);

// ===========================================================
// Channel numbers of the conversion port
localparam [2:0] CH_PROX_ONE = 3'h0;
localparam [2:0] CH_PROX_TWO = 3'h1;
localparam [2:0] CH_PROX_THREE = 3'h2;
localparam [2:0] CH_RESERVED = 3'h3;
localparam [2:0] CH_AMB_VIS = 3'h4;
localparam [2:0] CH_AMB_IR = 3'h5;
localparam [2:0] CH_AUX = 3'h6;
localparam [2:0] CH_UV = 3'h7;
// Result slots
localparam [2:0] SLOT_PROX_ONE = 3'h0;
localparam [2:0] SLOT_PROX_TWO = 3'h1;
localparam [2:0] SLOT_PROX_THREE = 3'h2;
localparam [2:0] SLOT_AMB_VIS = 3'h3;
localparam [2:0] SLOT_AMB_IR = 3'h4;
localparam [2:0] SLOT_AUX = 3'h5;

// ===========================================================
// Output reset values follow the entry reset values
localparam [7:0] EMITTER_ONE_TWO_RESET = `RST_EMITTER_SELECT_ONE_TWO;
localparam [7:0] EMITTER_THREE_RESET = `RST_EMITTER_SELECT_THREE;
localparam [7:0] INFRARED_GAIN_RESET = `RST_AMBIENT_INFRARED_GAIN;
localparam [7:0] INFRARED_RANGE_RESET = `RST_AMBIENT_INFRARED_RANGE;

reg [7:0] pending_bus_address_reg;
reg [7:0] channel_enable_list_reg;
reg [7:0] emitter_select_one_two_reg;
reg [7:0] emitter_select_three_reg;
reg [7:0] proximity_alignment_reg;
reg [7:0] ambient_alignment_reg;
reg [7:0] ambient_infrared_gain_reg;
reg [7:0] ambient_infrared_range_reg;
reg [7:0] rdata_next;
reg low_align;
reg [2:0] slot_next;

// ===========================================================
// Named fields of the enable list, emitter, alignment and infrared entries
wire uv_index_enable;
wire aux_channel_enable;
wire ambient_infrared_enable;
wire ambient_visible_enable;
wire proximity_three_enable;
wire proximity_two_enable;
wire proximity_one_enable;
wire proximity_one_low_align;
wire proximity_two_low_align;
wire proximity_three_low_align;
wire ambient_infrared_low_align;
wire ambient_visible_low_align;
wire [2:0] emitter_field_one;
wire [2:0] emitter_field_two;
wire [2:0] emitter_field_three;
wire [3:0] infrared_gain_field;
wire infrared_range_field;
wire [7:0] enable_by_code;
wire [CHANNEL_COUNT:0] channel_accept;
wire conv_accepted;
wire [15:0] aligned_value;

assign uv_index_enable = channel_enable_list_reg[`BIT_UV_INDEX_ENABLE];
assign aux_channel_enable = channel_enable_list_reg[`BIT_AUX_ENABLE];
assign ambient_infrared_enable = channel_enable_list_reg[`BIT_AMBIENT_INFRARED_ENABLE];
assign ambient_visible_enable = channel_enable_list_reg[`BIT_AMBIENT_VISIBLE_ENABLE];
assign proximity_three_enable = channel_enable_list_reg[`BIT_PROXIMITY_THREE_ENABLE];
assign proximity_two_enable = channel_enable_list_reg[`BIT_PROXIMITY_TWO_ENABLE];
assign proximity_one_enable = channel_enable_list_reg[`BIT_PROXIMITY_ONE_ENABLE];
assign proximity_one_low_align = proximity_alignment_reg[`BIT_PROXIMITY_ONE_ALIGN];
assign proximity_two_low_align = proximity_alignment_reg[`BIT_PROXIMITY_TWO_ALIGN];
assign proximity_three_low_align = proximity_alignment_reg[`BIT_PROXIMITY_THREE_ALIGN];
// Ambient pairing follows the field names: bit 5 infrared, bit 4 visible
assign ambient_infrared_low_align = ambient_alignment_reg[`BIT_AMBIENT_INFRARED_ALIGN];
assign ambient_visible_low_align = ambient_alignment_reg[`BIT_AMBIENT_VISIBLE_ALIGN];
assign emitter_field_one = emitter_select_one_two_reg[2:0];
assign emitter_field_two = emitter_select_one_two_reg[6:4];
assign emitter_field_three = emitter_select_three_reg[2:0];
assign infrared_gain_field = ambient_infrared_gain_reg[3:0];
assign infrared_range_field = ambient_infrared_range_reg[`BIT_INFRARED_RANGE_SELECT];
assign enable_by_code = {uv_index_enable, aux_channel_enable,
  ambient_infrared_enable, ambient_visible_enable, 1'b0,
  proximity_three_enable, proximity_two_enable, proximity_one_enable};
assign aligned_value = low_align ? conv_value[15:0] : conv_value[16:1];
assign conv_accepted = conv_valid && channel_accept[conv_channel];

// ===========================================================
// Per-code acceptance, code 3 sits on the reserved enable bit and never answers
genvar code;
generate
  for (code = 0; code <= CHANNEL_COUNT; code = code + 1)
  begin : accept_gen
    if (code == CH_RESERVED)
    begin : reserved_code
      assign channel_accept[code] = 1'b0;
    end
    else
    begin : live_code
      assign channel_accept[code] = enable_by_code[code];
    end
  end
endgenerate

// ===========================================================
// Register writes
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    pending_bus_address_reg <= `RST_PENDING_BUS_ADDRESS;
    channel_enable_list_reg <= `RST_CHANNEL_ENABLE_LIST;
    emitter_select_one_two_reg <= `RST_EMITTER_SELECT_ONE_TWO;
    emitter_select_three_reg <= `RST_EMITTER_SELECT_THREE;
    proximity_alignment_reg <= `RST_PROXIMITY_ALIGNMENT;
    ambient_alignment_reg <= `RST_AMBIENT_ALIGNMENT;
    ambient_infrared_gain_reg <= `RST_AMBIENT_INFRARED_GAIN;
    ambient_infrared_range_reg <= `RST_AMBIENT_INFRARED_RANGE;
  end
  else if (reg_write)
  begin
    // Reserved bits are masked on entry so they can never steer anything
    case (reg_addr)
      `OFS_PENDING_BUS_ADDRESS: pending_bus_address_reg <= reg_wdata;
      `OFS_CHANNEL_ENABLE_LIST: channel_enable_list_reg <= reg_wdata & `MASK_CHANNEL_ENABLE_LIST;
      `OFS_EMITTER_SELECT_ONE_TWO: emitter_select_one_two_reg <= reg_wdata & `MASK_EMITTER_SELECT_ONE_TWO;
      `OFS_EMITTER_SELECT_THREE: emitter_select_three_reg <= reg_wdata & `MASK_EMITTER_SELECT_THREE;
      `OFS_PROXIMITY_ALIGNMENT: proximity_alignment_reg <= reg_wdata & `MASK_PROXIMITY_ALIGNMENT;
      `OFS_AMBIENT_ALIGNMENT: ambient_alignment_reg <= reg_wdata & `MASK_AMBIENT_ALIGNMENT;
      `OFS_AMBIENT_INFRARED_GAIN: ambient_infrared_gain_reg <= reg_wdata & `MASK_AMBIENT_INFRARED_GAIN;
      `OFS_AMBIENT_INFRARED_RANGE: ambient_infrared_range_reg <= reg_wdata & `MASK_AMBIENT_INFRARED_RANGE;
      default:
      begin
      end
    endcase
  end
end

// ===========================================================
// Read port, data one cycle after the strobe, unmapped reads zero
always @*
begin
  case (reg_addr)
    `OFS_PENDING_BUS_ADDRESS: rdata_next = pending_bus_address_reg;
    `OFS_CHANNEL_ENABLE_LIST: rdata_next = channel_enable_list_reg;
    `OFS_EMITTER_SELECT_ONE_TWO: rdata_next = emitter_select_one_two_reg;
    `OFS_EMITTER_SELECT_THREE: rdata_next = emitter_select_three_reg;
    `OFS_PROXIMITY_ALIGNMENT: rdata_next = proximity_alignment_reg;
    `OFS_AMBIENT_ALIGNMENT: rdata_next = ambient_alignment_reg;
    `OFS_AMBIENT_INFRARED_GAIN: rdata_next = ambient_infrared_gain_reg;
    `OFS_AMBIENT_INFRARED_RANGE: rdata_next = ambient_infrared_range_reg;
    default: rdata_next = 8'h00;
  endcase
end

always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
    reg_rdata <= 8'h00;
  else if (reg_read)
    reg_rdata <= rdata_next;
  else
    reg_rdata <= 8'h00;
end

// ===========================================================
// Active bus address and configuration outputs
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    active_bus_address <= `RST_ACTIVE_BUS_ADDRESS;
    channel_enables <= `RST_CHANNEL_ENABLE_LIST;
    emitter_mask_one <= EMITTER_ONE_TWO_RESET[2:0];
    emitter_mask_two <= EMITTER_ONE_TWO_RESET[6:4];
    emitter_mask_three <= EMITTER_THREE_RESET[2:0];
    infrared_gain <= INFRARED_GAIN_RESET[3:0];
    infrared_range_select <= INFRARED_RANGE_RESET[`BIT_INFRARED_RANGE_SELECT];
  end
  else
  begin
    // Entry write alone never moves the live address, a mid-transfer change would drop the host
    if (bus_address_apply_command)
      active_bus_address <= pending_bus_address_reg;
    channel_enables <= channel_enable_list_reg;
    // Outputs lag the entries by one cycle so every port leaves a flop
    emitter_mask_one <= emitter_field_one;
    emitter_mask_two <= emitter_field_two;
    emitter_mask_three <= emitter_field_three;
    infrared_gain <= infrared_gain_field;
    infrared_range_select <= infrared_range_field;
  end
end

// ===========================================================
// Result alignment and slot routing
always @*
begin
  low_align = 1'b0;
  slot_next = SLOT_AUX;
  case (conv_channel)
    CH_PROX_ONE:
    begin
      low_align = proximity_one_low_align;
      slot_next = SLOT_PROX_ONE;
    end
    CH_PROX_TWO:
    begin
      low_align = proximity_two_low_align;
      slot_next = SLOT_PROX_TWO;
    end
    CH_PROX_THREE:
    begin
      low_align = proximity_three_low_align;
      slot_next = SLOT_PROX_THREE;
    end
    CH_AMB_VIS:
    begin
      low_align = ambient_visible_low_align;
      slot_next = SLOT_AMB_VIS;
    end
    CH_AMB_IR:
    begin
      low_align = ambient_infrared_low_align;
      slot_next = SLOT_AMB_IR;
    end
    default:
    begin
      low_align = 1'b0;
      slot_next = SLOT_AUX;
    end
  endcase
end

always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    result_valid <= 1'b0;
    result_slot <= 3'h0;
    result_data <= 16'h0000;
  end
  else
  begin
    // Conversions for disabled channels raise no result_valid, but result_slot and result_data still load on any conv_valid
    result_valid <= conv_accepted;
    if (conv_valid)
    begin
      result_slot <= slot_next;
      result_data <= aligned_value;
    end
  end
end

endmodule // sensor_parameter_config

// File: verif/sensor_param_checker.sv
/*
  Port-level assertions for the sensor parameter bank.
  Assumes binding into sensor_parameter_config, single clock domain.
*/
`timescale 1ns/100ps
module sensor_param_checker (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire bus_address_apply_command,
  input wire [7:0] active_bus_address,
  input wire [7:0] channel_enables,
  input wire conv_valid,
  input wire [2:0] conv_channel,
  input wire result_valid,
  input wire [2:0] result_slot
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ===========================================================
  // Assertions
  // The enable copy lags one cycle, so the edge right after a write is skipped
  chk_unmapped_read_zero:
    assert property (reg_read && reg_addr == 8'h04 |=> reg_rdata == 8'h00) else $error("Unmapped read not zero");
  chk_address_held:
    assert property (!$past(bus_address_apply_command) |-> $stable(active_bus_address)) else $error("Address moved");
  chk_reserved_silent:
    assert property (conv_valid && conv_channel == 3'h3 |=> !result_valid) else $error("Reserved channel answered");
  chk_no_spurious:
    assert property (!conv_valid |=> !result_valid) else $error("Result without conversion");
  chk_enabled_answers:
    assert property (conv_valid && conv_channel != 3'h3 && channel_enables[conv_channel] && !$past(reg_write)
      |=> result_valid) else $error("Enabled channel silent");
  chk_disabled_silent:
    assert property (conv_valid && !channel_enables[conv_channel] && !$past(reg_write) |=> !result_valid)
      else $error("Disabled channel answered");
  chk_uv_slot:
    assert property (conv_valid && conv_channel == 3'h7 |=> result_slot == 3'h5) else $error("UV slot wrong");
  chk_aux_slot:
    assert property (conv_valid && conv_channel == 3'h6 |=> result_slot == 3'h5) else $error("Aux slot wrong");
endmodule // sensor_param_checker
bind sensor_parameter_config sensor_param_checker chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
  .bus_address_apply_command(bus_address_apply_command), .active_bus_address(active_bus_address),
  .channel_enables(channel_enables), .conv_channel(conv_channel), .result_valid(result_valid),
  .result_slot(result_slot));

// File: verif/conversion_source.sv
/*
  Behavioural conversion source standing in for the measurement sequencer.
  Assumes start is a one-cycle request driven just after a rising edge.
*/
`timescale 1ns/100ps
module conversion_source (
  input wire clk,
  input wire start,
  input wire [2:0] start_channel,
  input wire [16:0] start_value,
  output reg conv_valid,
  output reg [2:0] conv_channel,
  output reg [16:0] conv_value
);
  initial
  begin
    conv_valid = 1'b0;
    conv_channel = 3'h0;
    conv_value = 17'h00000;
  end
  // Idle channel and value toggle so stale data never passes for a sample
  always @(posedge clk)
  begin
    conv_valid <= start;
    conv_channel <= start ? start_channel : ~conv_channel;
    conv_value <= start ? start_value : ~conv_value;
  end
endmodule // conversion_source

// File: verif/testbench.sv
/*
  Self-checking bench for the sensor parameter bank.
  Assumes the bound checker and the conversion source model.
*/
`timescale 1ns/100ps
module testbench;
  reg clk, sys_rst, reg_write, reg_read, apply, start;
  reg [7:0] reg_addr, reg_wdata;
  reg [2:0] start_channel;
  reg [16:0] start_value;
  wire [7:0] reg_rdata, active_bus_address, channel_enables;
  wire [2:0] emitter_mask_one, emitter_mask_two, emitter_mask_three, conv_channel, result_slot;
  wire [3:0] infrared_gain;
  wire infrared_range_select, conv_valid, result_valid;
  wire [16:0] conv_value;
  wire [15:0] result_data;
  integer mismatches, tests_run, i;
  localparam [63:0] OFS = 64'h00010203_05061e1f;
  localparam [63:0] RSTV = 64'h00002104_00000000;
  localparam [63:0] MSK = 64'hfff77707_70300f20;
  localparam [16:0] V = 17'h1a5c3;
  sensor_parameter_config dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .bus_address_apply_command(apply),
    .active_bus_address(active_bus_address), .channel_enables(channel_enables), .emitter_mask_one(emitter_mask_one),
    .emitter_mask_two(emitter_mask_two), .emitter_mask_three(emitter_mask_three), .infrared_gain(infrared_gain),
    .infrared_range_select(infrared_range_select), .conv_valid(conv_valid), .conv_channel(conv_channel),
    .conv_value(conv_value), .result_valid(result_valid), .result_slot(result_slot), .result_data(result_data));
  conversion_source src_u (.clk(clk), .start(start), .start_channel(start_channel), .start_value(start_value),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_value(conv_value));
  // ===========================================================
  // Bus and check tasks
  task check(input ok, input [8*16:1] what);
    begin
      tests_run = tests_run + 1;
      if (!ok)
      begin
        mismatches = mismatches + 1;
        $display("ERROR at %0t: %0s", $time, what);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata === e, "read data");
    end
  endtask
  task settle;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task conv(input [2:0] ch, input ev, input [2:0] es, input [15:0] ed, input cd);
    begin
      @(posedge clk);
      start <= 1'b1;
      start_channel <= ch;
      start_value <= V;
      @(posedge clk);
      start <= 1'b0;
      settle;
      check(result_valid === ev, "result valid");
      if (ev)
        check(result_slot === es && (!cd || result_data === ed), "result slot/data");
    end
  endtask
  // ===========================================================
  // Scenarios
  task reset_values;
    begin
      check(active_bus_address === 8'h00 && channel_enables === 8'h00 && infrared_gain === 4'h0, "reset outputs");
      check({emitter_mask_three, emitter_mask_two, emitter_mask_one} === 9'h111, "reset masks");
      for (i = 0; i < 8; i = i + 1)
        rd(OFS[63-8*i -: 8], RSTV[63-8*i -: 8]);
      rd(8'h04, 8'h00);
    end
  endtask
  task reserved_bits;
    begin
      for (i = 0; i < 8; i = i + 1)
        wr(OFS[63-8*i -: 8], 8'hff);
      for (i = 0; i < 8; i = i + 1)
        rd(OFS[63-8*i -: 8], MSK[63-8*i -: 8]);
      check(channel_enables === 8'hf7 && infrared_gain === 4'hf && infrared_range_select === 1'b1, "fields");
      check(active_bus_address === 8'h00, "address early");
    end
  endtask
  task address_apply;
    begin
      wr(8'h00, 8'h5a);
      settle;
      check(active_bus_address === 8'h00, "address early");
      @(posedge clk) apply <= 1'b1;
      @(posedge clk);
      apply <= 1'b0;
      #1 check(active_bus_address === 8'h5a, "address apply");
    end
  endtask
  task emitter_masks;
    begin
      wr(8'h02, 8'h53);
      wr(8'h03, 8'h03);
      settle;
      check({emitter_mask_three, emitter_mask_two, emitter_mask_one} === 9'h0eb, "masks");
    end
  endtask
  task channels;
    begin
      wr(8'h05, 8'h50);
      wr(8'h06, 8'h20);
      for (i = 0; i < 8; i = i + 1)
      begin
        wr(8'h01, 8'h01 << i);
        settle;
        conv(i[2:0], i != 3, (i < 3) ? i[2:0] : (i < 6) ? i[2:0] - 3'h1 : 3'h5,
          (i == 0 || i == 2 || i == 5) ? V[15:0] : V[16:1], i < 6);
        conv(i[2:0] + 3'h1, 1'b0, 3'h0, 16'h0000, 1'b0);
      end
    end
  endtask
  task complete_run;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ===========================================================
  // Clock, sequence and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {sys_rst, reg_write, reg_read, apply, start} = 5'h10;
    {reg_addr, reg_wdata, start_channel, start_value} = 36'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    settle;
    reset_values;
    reserved_bits;
    address_apply;
    emitter_masks;
    channels;
    complete_run;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule // testbench
